// File: common/dfp_consts.svh
// constants for the data flash protection block
`ifndef DFP_CONSTS_SVH
`define DFP_CONSTS_SVH

// register offsets on the plain register port
`define DFP_OFS_PROT     8'h00
`define DFP_OFS_STAT     8'h01
`define DFP_OFS_MASK     8'h02

// protection register layout
`define DFP_OPEN_BIT     7
`define DFP_SIZE_MSB     4
`define DFP_SIZE_LSB     0
`define DFP_PROT_FULL    8'h1F
`define DFP_PROT_RMASK   8'h9F
`define DFP_OPEN_RST     1'b0
`define DFP_SIZE_FULL    5'h1F

// status and mask layout
`define DFP_STAT_VIOL    0
`define DFP_STAT_DONE    1
`define DFP_STAT_WIDTH   2
`define DFP_STAT_RST     2'h0

// protected window geometry
`define DFP_BASE_ADDR    24'h10_0000
`define DFP_UNIT_SHIFT   8
`define DFP_UNIT_BYTES   24'h00_0100
`define DFP_ARRAY_BYTES  24'h00_2000
`define DFP_SECTOR_BYTES 24'h00_0100

`endif

// File: common/dfp_pkg.sv
// types for the data flash protection block
package dfp_pkg;

  // flash operation that asks to change data flash contents
  typedef enum logic [1:0] {
    DFP_OP_PROGRAM,
    DFP_OP_SECTOR_ERASE,
    DFP_OP_BLOCK_ERASE,
    DFP_OP_OTHER
  } dfp_op_kind_t;

  typedef struct packed {
    logic         valid;
    dfp_op_kind_t kind;
    logic [23:0]  addr;
  } dfp_op_req_t;

  typedef struct packed {
    logic       open;
    logic [4:0] size;
  } dfp_prot_t;

  typedef enum {
    DFP_ST_LOADING,
    DFP_ST_RUN
  } dfp_state_t;

endpackage

// File: hw/dfp_window.sv
// decodes the size field into the protected window length
`timescale 1ns/1ns
`include "dfp_consts.svh"
module dfp_window #(
  parameter logic [23:0] ARRAY_BYTES = `DFP_ARRAY_BYTES
) (
  input  wire logic [4:0]  sizeCode,  // protection size field
  output logic      [23:0] winBytes   // protected length from base
);
  logic [23:0] units;
  logic [23:0] rawBytes;

  // each size step adds one unit above the base, capped at array end
  assign units    = 24'(sizeCode) + 24'h00_0001;
  assign rawBytes = units << `DFP_UNIT_SHIFT;
  assign winBytes = (rawBytes > ARRAY_BYTES) ? ARRAY_BYTES : rawBytes;
endmodule

// File: hw/dfp_check.sv
// judges one flash operation against the protected window
`timescale 1ns/1ns
`include "dfp_consts.svh"
module dfp_check #(
  parameter logic [23:0] SECTOR_BYTES = `DFP_SECTOR_BYTES
) (
  input  wire dfp_pkg::dfp_op_req_t req,       // operation request
  input  wire logic                 protOpen,  // protection disabled
  input  wire logic [23:0]          winBytes,  // protected length
  output logic                      deny       // operation refused
);
  // true when the address falls in base .. base+len-1
  function automatic logic inWindow(input logic [23:0] a,
                                    input logic [23:0] len);
    logic [23:0] off;
    off = a - `DFP_BASE_ADDR;
    return (a >= `DFP_BASE_ADDR) && (off < len);
  endfunction

  logic [23:0] sectorBase;

  // the erase hits its whole sector, so check the sector start
  assign sectorBase = req.addr & ~(SECTOR_BYTES - 24'h00_0001);

  always_comb begin
    deny = 1'b0;
    if (!protOpen) begin
      case (req.kind)
        dfp_pkg::DFP_OP_PROGRAM:      deny = inWindow(req.addr, winBytes);
        dfp_pkg::DFP_OP_SECTOR_ERASE: deny = inWindow(sectorBase, winBytes);
        // smallest window is one sector, so a closed guard blocks it
        dfp_pkg::DFP_OP_BLOCK_ERASE:  deny = 1'b1;
        default:                      deny = 1'b0;
      endcase
    end
  end
endmodule

// File: hw/data_flash_protection.sv
// data flash protection: register, load at reset, operation guard
//
// Overview of operation
// - failed protection byte load clears open bit, sets all size bits
// - program or erase inside protected space is refused, violation set
// - block erase refused whenever any data flash sector is protected
// - open bit 7 low enables protection by size field; high disables it
// - five bit size field at bits 4..0 selects protected area size
// - window starts at 0x10_0000; codes 0..3 protect 256..1024 bytes
`timescale 1ns/1ns
`include "dfp_consts.svh"
module data_flash_protection #(
  parameter logic [23:0] ARRAY_BYTES  = `DFP_ARRAY_BYTES,
  parameter logic [23:0] SECTOR_BYTES = `DFP_SECTOR_BYTES
) (
  input  wire logic                 sys_clk,    // 50 MHz clock
  input  wire logic                 reset,      // sync, active high
  input  wire logic [7:0]           regAddr,    // register offset
  input  wire logic [7:0]           regWdata,   // register write data
  input  wire logic                 regWr,      // write strobe
  input  wire logic                 regRd,      // read strobe
  output logic      [7:0]           regRdata,   // read data, next cycle
  input  wire logic                 loadValid,  // protection byte fetched
  input  wire logic                 loadOk,     // fetch was error free
  input  wire logic [7:0]           loadByte,   // fetched protection byte
  input  wire dfp_pkg::dfp_op_req_t opReq,      // flash operation request
  output logic                      opGrant,    // operation allowed pulse
  output logic                      opDeny,     // operation refused pulse
  output logic                      irq         // level interrupt
);
  dfp_pkg::dfp_state_t              state_r;
  dfp_pkg::dfp_prot_t               prot_r;
  logic [`DFP_STAT_WIDTH-1:0]       stat_r;
  logic [`DFP_STAT_WIDTH-1:0]       mask_r;
  logic [7:0]                       rdata_r;
  logic                             grant_r;
  logic                             deny_r;
  logic                             irq_r;
  logic [23:0]                      winBytes;
  logic                             guardDeny;
  logic                             denyNow;
  logic                             grantNow;
  logic [7:0]                       protByte;
  logic                             wrProt;
  logic                             wrStat;
  logic                             wrMask;

  // address decode of the plain register port
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  assign wrProt = regWr && hit(regAddr, `DFP_OFS_PROT);
  assign wrStat = regWr && hit(regAddr, `DFP_OFS_STAT);
  assign wrMask = regWr && hit(regAddr, `DFP_OFS_MASK);

  // reserved bits 6..5 always read zero
  assign protByte = {prot_r.open, 2'b00, prot_r.size};

  dfp_window #(
    .ARRAY_BYTES (ARRAY_BYTES)
  ) u_window (
    .sizeCode (prot_r.size),
    .winBytes (winBytes)
  );

  dfp_check #(
    .SECTOR_BYTES (SECTOR_BYTES)
  ) u_check (
    .req      (opReq),
    .protOpen (prot_r.open),
    .winBytes (winBytes),
    .deny     (guardDeny)
  );

  // until the byte is loaded the window is unknown, so refuse every program and erase
  always_comb begin
    denyNow  = 1'b0;
    grantNow = 1'b0;
    if (opReq.valid && opReq.kind != dfp_pkg::DFP_OP_OTHER) begin
      case (state_r)
        dfp_pkg::DFP_ST_LOADING: denyNow = 1'b1;
        dfp_pkg::DFP_ST_RUN: begin
          denyNow  = guardDeny;
          grantNow = !guardDeny;
        end
        default: denyNow = 1'b1;
      endcase
    end
  end

  // reset sequence state: waits for the protection byte fetch
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= dfp_pkg::DFP_ST_LOADING;
    end else begin
      case (state_r)
        dfp_pkg::DFP_ST_LOADING: begin
          if (loadValid) begin
            state_r <= dfp_pkg::DFP_ST_RUN;
          end
        end
        dfp_pkg::DFP_ST_RUN: state_r <= dfp_pkg::DFP_ST_RUN;
        default:             state_r <= dfp_pkg::DFP_ST_LOADING;
      endcase
    end
  end

  // protection register; the fetch wins over a software write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prot_r.open <= `DFP_OPEN_RST;
      prot_r.size <= `DFP_SIZE_FULL;
    end else if (loadValid && state_r == dfp_pkg::DFP_ST_LOADING) begin
      if (loadOk) begin
        prot_r.open <= loadByte[`DFP_OPEN_BIT];
        prot_r.size <= loadByte[`DFP_SIZE_MSB:`DFP_SIZE_LSB];
      end else begin
        prot_r.open <= `DFP_OPEN_RST;
        prot_r.size <= `DFP_SIZE_FULL;
      end
    end else if (wrProt) begin
      prot_r.open <= regWdata[`DFP_OPEN_BIT];
      prot_r.size <= regWdata[`DFP_SIZE_MSB:`DFP_SIZE_LSB];
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stat_r <= `DFP_STAT_RST;
    end else begin
      if (wrStat) begin
        stat_r <= stat_r & ~regWdata[`DFP_STAT_WIDTH-1:0];
      end
      if (denyNow) begin
        stat_r[`DFP_STAT_VIOL] <= 1'b1;
      end
      if (grantNow) begin
        stat_r[`DFP_STAT_DONE] <= 1'b1;
      end
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mask_r <= `DFP_STAT_RST;
    end else if (wrMask) begin
      mask_r <= regWdata[`DFP_STAT_WIDTH-1:0];
    end
  end

  // operation answer pulses, one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      grant_r <= 1'b0;
      deny_r  <= 1'b0;
    end else begin
      grant_r <= grantNow;
      deny_r  <= denyNow;
    end
  end

  // interrupt follows status one cycle late to stay a flop output
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & mask_r);
    end
  end

  // read data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `DFP_OFS_PROT: rdata_r <= protByte;
        `DFP_OFS_STAT: rdata_r <= 8'(stat_r);
        `DFP_OFS_MASK: rdata_r <= 8'(mask_r);
        default:       rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign regRdata = rdata_r;
  assign opGrant  = grant_r;
  assign opDeny   = deny_r;
  assign irq      = irq_r;

  // checks on the guard behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic running;
  logic isProg;
  logic isBlock;
  logic isErase;
  logic atFirst;
  assign running = state_r == dfp_pkg::DFP_ST_RUN;
  assign isProg  = opReq.valid && opReq.kind == dfp_pkg::DFP_OP_PROGRAM;
  assign isBlock = opReq.valid && opReq.kind == dfp_pkg::DFP_OP_BLOCK_ERASE;
  assign isErase = opReq.valid &&
                   opReq.kind == dfp_pkg::DFP_OP_SECTOR_ERASE;
  // first sector of the window, protected at every size code
  assign atFirst = opReq.addr >= `DFP_BASE_ADDR &&
                   opReq.addr <  `DFP_BASE_ADDR + `DFP_UNIT_BYTES;

  sequence seq_denied;
    opDeny && !opGrant && stat_r[`DFP_STAT_VIOL];
  endsequence

  sequence seq_granted;
    opGrant && !opDeny;
  endsequence

  sequence seq_prog_at(logic [23:0] a);
    running && isProg && !prot_r.open && opReq.addr == a;
  endsequence

  viol_flag_a: assert property (
    running && isProg && !prot_r.open &&
    opReq.addr == `DFP_BASE_ADDR |=> seq_denied)
    else $error("protected program not refused");

  block_refuse_a: assert property (
    running && isBlock && !prot_r.open |=> seq_denied)
    else $error("block erase allowed while protected");

  open_pass_a: assert property (
    running && opReq.valid && prot_r.open &&
    opReq.kind != dfp_pkg::DFP_OP_OTHER |=> seq_granted)
    else $error("open protection refused an operation");

  bad_load_a: assert property (
    state_r == dfp_pkg::DFP_ST_LOADING && loadValid && !loadOk
    |=> protByte == `DFP_PROT_FULL ##1 protByte == `DFP_PROT_FULL
        || $past(wrProt))
    else $error("failed load did not fully protect");

  size_write_a: assert property (
    wrProt && running |=>
    protByte == ($past(regWdata) & `DFP_PROT_RMASK))
    else $error("protection register write lost");

  base_below_a: assert property (
    seq_prog_at(`DFP_BASE_ADDR - 24'h00_0001) |=> seq_granted)
    else $error("address below base was protected");

  size_zero_a: assert property (
    prot_r.size == 5'h00 ##0
    seq_prog_at(`DFP_BASE_ADDR + `DFP_UNIT_BYTES) |=> seq_granted)
    else $error("size zero protected past 256 bytes");

  size_three_a: assert property (
    prot_r.size == 5'h03 ##0
    seq_prog_at(`DFP_BASE_ADDR + 24'h00_03FF) |=> seq_denied)
    else $error("size three left its last byte open");

  size_step_a: assert property (
    $past(prot_r.size) != `DFP_SIZE_FULL &&
    prot_r.size == $past(prot_r.size) + 5'h01 &&
    $past(winBytes) + `DFP_UNIT_BYTES <= ARRAY_BYTES
    |-> winBytes == $past(winBytes) + `DFP_UNIT_BYTES)
    else $error("window did not grow by one unit");

  irq_level_a: assert property (
    (stat_r & mask_r) != `DFP_STAT_RST ##1 (stat_r & mask_r) != 2'h0
    |-> irq)
    else $error("interrupt low with unmasked status");

  loading_deny_a: assert property (
    !running && opReq.valid && opReq.kind != dfp_pkg::DFP_OP_OTHER
    |=> opDeny [*1] ##0 !opGrant)
    else $error("operation taken before protection loaded");

  sector_erase_a: assert property (
    running && isErase && !prot_r.open && atFirst |=> seq_denied)
    else $error("protected sector erase not refused");

  load_copy_a: assert property (
    state_r == dfp_pkg::DFP_ST_LOADING && loadValid && loadOk
    |=> protByte == ($past(loadByte) & `DFP_PROT_RMASK))
    else $error("loaded protection byte not applied");

  set_wins_a: assert property (
    wrStat && regWdata[`DFP_STAT_VIOL] && denyNow
    |=> stat_r[`DFP_STAT_VIOL])
    else $error("status clear beat a new violation");

  grant_done_a: assert property (
    grantNow |=> seq_granted ##0 stat_r[`DFP_STAT_DONE])
    else $error("granted operation not flagged done");

  rd_idle_a: assert property (
    !regRd |=> regRdata == 8'h00)
    else $error("read data shown without a read strobe");
endmodule

// File: sim/tb.sv
// self-checking bench for the data flash protection block
`timescale 1ns/1ns
`include "dfp_consts.svh"
module tb;
  typedef struct packed {
    logic [7:0]            prot;
    dfp_pkg::dfp_op_kind_t kind;
    logic [23:0]           addr;
    logic                  deny;
  } dfp_row_t;

  localparam dfp_pkg::dfp_op_kind_t PG = dfp_pkg::DFP_OP_PROGRAM;
  localparam dfp_pkg::dfp_op_kind_t SE = dfp_pkg::DFP_OP_SECTOR_ERASE;
  localparam dfp_pkg::dfp_op_kind_t BE = dfp_pkg::DFP_OP_BLOCK_ERASE;
  localparam dfp_pkg::dfp_op_kind_t OT = dfp_pkg::DFP_OP_OTHER;
  localparam int NROWS = 19;
  // window edges for size codes 0 to 4 and 0x1F, plus open and erase kinds
  localparam dfp_row_t ROWS [NROWS] = '{
    '{8'h00, PG, 24'h10_0000, 1'b1}, '{8'h00, PG, 24'h10_00FF, 1'b1},
    '{8'h00, PG, 24'h10_0100, 1'b0}, '{8'h00, PG, 24'h0F_FFFF, 1'b0},
    '{8'h01, PG, 24'h10_01FF, 1'b1}, '{8'h01, PG, 24'h10_0200, 1'b0},
    '{8'h02, PG, 24'h10_02FF, 1'b1}, '{8'h02, PG, 24'h10_0300, 1'b0},
    '{8'h03, PG, 24'h10_03FF, 1'b1}, '{8'h03, PG, 24'h10_0400, 1'b0},
    '{8'h04, PG, 24'h10_04FF, 1'b1}, '{8'h04, PG, 24'h10_0500, 1'b0},
    '{8'h1F, PG, 24'h10_1FFF, 1'b1}, '{8'h00, SE, 24'h10_00FF, 1'b1},
    '{8'h00, SE, 24'h10_0180, 1'b0}, '{8'h00, BE, 24'h10_0000, 1'b1},
    '{8'h80, PG, 24'h10_0000, 1'b0}, '{8'h80, BE, 24'h10_0000, 1'b0},
    '{8'h9F, SE, 24'h10_0000, 1'b0}
  };

  logic                 sys_clk;
  logic                 reset;
  logic [7:0]           regAddr;
  logic [7:0]           regWdata;
  logic                 regWr;
  logic                 regRd;
  logic [7:0]           regRdata;
  logic                 loadValid;
  logic                 loadOk;
  logic [7:0]           loadByte;
  dfp_pkg::dfp_op_req_t opReq;
  logic                 opGrant;
  logic                 opDeny;
  logic                 irq;
  int                   bad_count;
  int                   check_count;
  logic                 rowDeny;

  data_flash_protection dut (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .regAddr   (regAddr),
    .regWdata  (regWdata),
    .regWr     (regWr),
    .regRd     (regRd),
    .regRdata  (regRdata),
    .loadValid (loadValid),
    .loadOk    (loadOk),
    .loadByte  (loadByte),
    .opReq     (opReq),
    .opGrant   (opGrant),
    .opDeny    (opDeny),
    .irq       (irq)
  );

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // strobes go high for one cycle, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask

  // answer pulse is looked at in the cycle after the request
  task automatic op(input dfp_pkg::dfp_op_kind_t k, input logic [23:0] a);
    @(posedge sys_clk);
    opReq <= '{valid: 1'b1, kind: k, addr: a};
    @(posedge sys_clk);
    opReq.valid <= 1'b0;
    #1;
  endtask

  task automatic ld(input logic ok, input logic [7:0] b);
    @(posedge sys_clk);
    loadValid <= 1'b1;
    loadOk    <= ok;
    loadByte  <= b;
    @(posedge sys_clk);
    loadValid <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    #1 chk({regRdata, irq, opDeny, opGrant}, 16'h0000);
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end

  initial begin
    reset = 1'b1; regAddr = 8'h00; regWdata = 8'h00; regWr = 1'b0;
    regRd = 1'b0; loadValid = 1'b0; loadOk = 1'b0; loadByte = 8'h00;
    opReq = '0; bad_count = 0; check_count = 0;
    do_reset();
    rd(`DFP_OFS_PROT, `DFP_PROT_FULL);
    op(PG, 24'h10_1000);
    chk({opDeny, opGrant}, 8'h2);
    // failed load leaves the whole array protected
    ld(1'b0, 8'hE0);
    rd(`DFP_OFS_PROT, `DFP_PROT_FULL);
    op(PG, 24'h10_1FFF);
    chk({opDeny, opGrant}, 8'h2);
    wr(`DFP_OFS_STAT, 8'h03);
    $display("test load_fail done");
    // reserved bits read back as zero
    wr(`DFP_OFS_PROT, 8'hFF);
    rd(`DFP_OFS_PROT, 8'h9F);
    wr(`DFP_OFS_PROT, 8'h15);
    rd(`DFP_OFS_PROT, 8'h15);
    wr(8'h05, 8'hAA);
    rd(8'h05, 8'h00);
    rd(`DFP_OFS_PROT, 8'h15);
    $display("test register done");
    // table of windows: answer pulse and sticky status per row
    for (int i = 0; i < NROWS; i++) begin
      rowDeny = ROWS[i].deny;
      wr(`DFP_OFS_PROT, ROWS[i].prot);
      op(ROWS[i].kind, ROWS[i].addr);
      chk({opDeny, opGrant}, {rowDeny, !rowDeny});
      rd(`DFP_OFS_STAT, {!rowDeny, rowDeny});
      wr(`DFP_OFS_STAT, 8'h03);
    end
    rd(`DFP_OFS_STAT, 8'h00);
    $display("test table done");
    // back-to-back requests, then an ignored kind
    wr(`DFP_OFS_PROT, 8'h00);
    @(posedge sys_clk);
    opReq <= '{valid: 1'b1, kind: BE, addr: 24'h10_0000};
    @(posedge sys_clk);
    opReq <= '{valid: 1'b1, kind: PG, addr: 24'h10_0100};
    #1 chk({opDeny, opGrant}, 8'h2);
    @(posedge sys_clk);
    opReq.valid <= 1'b0;
    #1 chk({opDeny, opGrant}, 8'h1);
    @(posedge sys_clk);
    #1 chk({opDeny, opGrant}, 8'h0);
    op(OT, 24'h10_0000);
    chk({opDeny, opGrant}, 8'h0);
    wr(`DFP_OFS_STAT, 8'h03);
    // a clear in the same cycle as a refusal leaves the flag set
    @(posedge sys_clk);
    regAddr  <= `DFP_OFS_STAT;
    regWdata <= 8'h03;
    regWr    <= 1'b1;
    opReq    <= '{valid: 1'b1, kind: PG, addr: 24'h10_0000};
    @(posedge sys_clk);
    regWr       <= 1'b0;
    opReq.valid <= 1'b0;
    rd(`DFP_OFS_STAT, 8'h01);
    wr(`DFP_OFS_STAT, 8'h03);
    $display("test back_to_back done");
    // interrupt raised, masked, unmasked, cleared
    wr(`DFP_OFS_MASK, 8'h01);
    op(PG, 24'h10_0000);
    @(posedge sys_clk);
    #1 chk(irq, 1'b1);
    wr(`DFP_OFS_MASK, 8'h00);
    @(posedge sys_clk);
    #1 chk(irq, 1'b0);
    wr(`DFP_OFS_MASK, 8'h01);
    rd(`DFP_OFS_MASK, 8'h01);
    chk(irq, 1'b1);
    wr(`DFP_OFS_STAT, 8'h01);
    @(posedge sys_clk);
    #1 chk(irq, 1'b0);
    $display("test interrupt done");
    // second reset: good load copies open and size bits only
    do_reset();
    rd(`DFP_OFS_PROT, `DFP_PROT_FULL);
    rd(`DFP_OFS_MASK, 8'h00);
    op(PG, 24'h10_1000);
    chk({opDeny, opGrant}, 8'h2);
    // good load beside a software write: the load wins
    @(posedge sys_clk);
    loadValid <= 1'b1;
    loadOk    <= 1'b1;
    loadByte  <= 8'hE3;
    regAddr   <= `DFP_OFS_PROT;
    regWdata  <= 8'h00;
    regWr     <= 1'b1;
    @(posedge sys_clk);
    loadValid <= 1'b0;
    regWr     <= 1'b0;
    rd(`DFP_OFS_PROT, 8'h83);
    op(BE, 24'h10_0000);
    chk({opDeny, opGrant}, 8'h1);
    ld(1'b0, 8'h00);
    rd(`DFP_OFS_PROT, 8'h83);
    $display("test reload done");
    end_sim();
  end
endmodule
